// [irq_status_pkg.sv]
// Constants for the interrupt status latch bank
package irq_status_pkg;
   localparam logic [9:0] ADDR_LINK_STATUS  = 10'h022;
   localparam logic [9:0] ADDR_DAC_PATTERN  = 10'h024;
   localparam logic [9:0] ADDR_PAIR_A       = 10'h025;
   localparam logic [9:0] ADDR_MODE_LINK    = 10'h01E;
   localparam logic [9:0] ADDR_MODE_PATTERN = 10'h01F;
   localparam logic [9:0] ADDR_MODE_PAIR_A  = 10'h020;
   localparam logic [9:0] ADDR_FIFO_FULL    = 10'h30C;
   localparam logic [9:0] ADDR_FIFO_EMPTY   = 10'h30D;
   localparam int BIT_PLL_LOCK    = 2;
   localparam int BIT_LANE_ERR    = 1;
   localparam int BIT_POWER       = 7;
   localparam int BIT_BLANK       = 5;
   localparam int BIT_NCO         = 4;
   localparam logic [7:0] MASK_LINK    = 8'h06;
   localparam logic [7:0] MASK_PATTERN = 8'h0F;
   localparam logic [7:0] MASK_PAIR_A  = 8'hB0;
   localparam logic [7:0] RESET_VALUE  = 8'h00;
endpackage : irq_status_pkg

// [status_flag_cell.sv]
// One status flag: live mirror or rising-edge capture with write-one clear
`timescale 1ns/10ps
module status_flag_cell (
   input  wire logic clk_i,     // Device clock
   input  wire logic rst_n_i,   // Synchronous reset, active low
   input  wire logic src_i,     // Source condition level
   input  wire logic mode_i,    // Capture mode select
   input  wire logic clr_i,     // Write-one-to-clear pulse
   output logic      status_o,  // Read-back value
   output logic      captured_o // Captured and holding
);
   logic src_prev_r;
   logic src_prev_nxt;
   logic cap_r;
   logic cap_nxt;

   always_comb begin
      src_prev_nxt = src_i;
      cap_nxt      = cap_r;
      if (!mode_i) begin
         cap_nxt = 1'b0;
      end else begin
         if (clr_i) begin
            cap_nxt = 1'b0;
         end
         if (src_i && !src_prev_r) begin
            cap_nxt = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         src_prev_r <= 1'b0;
         cap_r      <= 1'b0;
      end else begin
         src_prev_r <= src_prev_nxt;
         cap_r      <= cap_nxt;
      end
   end

   assign status_o   = mode_i ? cap_r : src_i;
   assign captured_o = mode_i & cap_r;

   cap_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (mode_i && cap_r && !clr_i && $stable(mode_i)) |=> cap_r)
      else $error("captured flag dropped without clear");
   cap_edge_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (mode_i && src_i && !src_prev_r) ##1 mode_i |-> cap_r)
      else $error("rising source not captured");
   live_mirror_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      !mode_i |-> status_o == src_i)
      else $error("status does not mirror source");
endmodule : status_flag_cell

// [irq_status_latch_bank.sv]
// Interrupt status bank with capture modes and register access port
`timescale 1ns/10ps
module irq_status_latch_bank
   import irq_status_pkg::*;
#(
   parameter int LANES = 8   // Number of serial lanes
) (
   input  wire logic             clk_i,          // Device clock
   input  wire logic             rst_n_i,        // Sync reset, active low
   input  wire logic [9:0]       reg_addr_i,     // Register address
   input  wire logic             reg_wr_i,       // Write strobe
   input  wire logic [7:0]       reg_wdata_i,    // Write data
   output logic      [7:0]       reg_rdata_o,    // Read data, registered
   input  wire logic             pll_locked_i,   // Serdes PLL locked
   input  wire logic             link_enable_i,  // Serial link enable
   input  wire logic [LANES-1:0] lane_full_i,    // Lane FIFO full
   input  wire logic [LANES-1:0] lane_empty_i,   // Lane FIFO empty
   input  wire logic [3:0]       pattern_err_i,  // Per-DAC check failure
   input  wire logic             power_over_i,   // Pair A over threshold
   input  wire logic             blank_done_i,   // Pair A blanking done
   input  wire logic             nco_trip_i,     // Pair A NCO align trip
   output logic                  irq_n_o         // Interrupt, active low
);
   localparam int NFLAG = 9;

   logic             lane_err_r;
   logic             lane_err_nxt;
   logic             link_en_prev_r;
   logic             link_en_prev_nxt;
   logic             link_off_seen_r;
   logic             link_off_seen_nxt;
   logic [7:0]       mode_link_r;
   logic [7:0]       mode_link_nxt;
   logic [7:0]       mode_pat_r;
   logic [7:0]       mode_pat_nxt;
   logic [7:0]       mode_pair_r;
   logic [7:0]       mode_pair_nxt;
   logic [7:0]       rdata_nxt;
   logic [7:0]       rdata_r;
   logic [NFLAG-1:0] src;
   logic [NFLAG-1:0] mode;
   logic [NFLAG-1:0] clr;
   logic [NFLAG-1:0] stat;
   logic [NFLAG-1:0] capd;
   logic [7:0]       link_stat;
   logic [7:0]       pat_stat;
   logic [7:0]       pair_stat;
   logic [10:0]      wr_req;

   // Write strobe and address travel together so every write decode sees both
   assign wr_req = {reg_wr_i, reg_addr_i};

   function automatic logic hit(input logic [10:0] q, input logic [9:0] a);
      hit = q[10] && (q[9:0] == a);
   endfunction : hit

   // Lane error stays sticky until the link goes down and comes back up
   always_comb begin
      link_en_prev_nxt  = link_enable_i;
      lane_err_nxt      = lane_err_r;
      link_off_seen_nxt = link_off_seen_r;
      if (!link_enable_i) begin
         link_off_seen_nxt = lane_err_r;
      end
      if (link_enable_i && !link_en_prev_r && link_off_seen_r) begin
         lane_err_nxt      = 1'b0;
         link_off_seen_nxt = 1'b0;
      end
      if (link_enable_i && ((|lane_full_i) || (|lane_empty_i))) begin
         lane_err_nxt = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         lane_err_r      <= 1'b0;
         link_en_prev_r  <= 1'b0;
         link_off_seen_r <= 1'b0;
      end else begin
         lane_err_r      <= lane_err_nxt;
         link_en_prev_r  <= link_en_prev_nxt;
         link_off_seen_r <= link_off_seen_nxt;
      end
   end

   // Capture mode select registers
   always_comb begin
      mode_link_nxt = mode_link_r;
      mode_pat_nxt  = mode_pat_r;
      mode_pair_nxt = mode_pair_r;
      if (hit(wr_req, ADDR_MODE_LINK)) begin
         mode_link_nxt = reg_wdata_i & MASK_LINK;
      end
      if (hit(wr_req, ADDR_MODE_PATTERN)) begin
         mode_pat_nxt = reg_wdata_i & MASK_PATTERN;
      end
      if (hit(wr_req, ADDR_MODE_PAIR_A)) begin
         mode_pair_nxt = reg_wdata_i & MASK_PAIR_A;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         mode_link_r <= RESET_VALUE;
         mode_pat_r  <= RESET_VALUE;
         mode_pair_r <= RESET_VALUE;
      end else begin
         mode_link_r <= mode_link_nxt;
         mode_pat_r  <= mode_pat_nxt;
         mode_pair_r <= mode_pair_nxt;
      end
   end

   // Flag order: pll, lane, dac0..3, power, blank, nco
   assign src  = {nco_trip_i, blank_done_i, power_over_i, pattern_err_i,
                  lane_err_r, pll_locked_i};
   assign mode = {mode_pair_r[BIT_NCO], mode_pair_r[BIT_BLANK],
                  mode_pair_r[BIT_POWER], mode_pat_r[3:0],
                  mode_link_r[BIT_LANE_ERR], mode_link_r[BIT_PLL_LOCK]};
   assign clr  = {hit(wr_req, ADDR_PAIR_A) & reg_wdata_i[BIT_NCO],
                  hit(wr_req, ADDR_PAIR_A) & reg_wdata_i[BIT_BLANK],
                  hit(wr_req, ADDR_PAIR_A) & reg_wdata_i[BIT_POWER],
                  {4{hit(wr_req, ADDR_DAC_PATTERN)}} & reg_wdata_i[3:0],
                  hit(wr_req, ADDR_LINK_STATUS) & reg_wdata_i[BIT_LANE_ERR],
                  hit(wr_req, ADDR_LINK_STATUS) & reg_wdata_i[BIT_PLL_LOCK]};

   for (genvar g = 0; g < NFLAG; g++) begin : g_flag
      status_flag_cell u_cell (
         .clk_i      (clk_i),
         .rst_n_i    (rst_n_i),
         .src_i      (src[g]),
         .mode_i     (mode[g]),
         .clr_i      (clr[g]),
         .status_o   (stat[g]),
         .captured_o (capd[g])
      );
   end

   assign link_stat = {5'h00, stat[0], stat[1], 1'b0};
   assign pat_stat  = {4'h0, stat[5:2]};
   assign pair_stat = {stat[6], 1'b0, stat[7], stat[8], 4'h0};

   // Read mux; unmapped addresses return zero
   always_comb begin
      case (reg_addr_i)
         ADDR_LINK_STATUS:  rdata_nxt = link_stat;
         ADDR_DAC_PATTERN:  rdata_nxt = pat_stat;
         ADDR_PAIR_A:       rdata_nxt = pair_stat;
         ADDR_MODE_LINK:    rdata_nxt = mode_link_r;
         ADDR_MODE_PATTERN: rdata_nxt = mode_pat_r;
         ADDR_MODE_PAIR_A:  rdata_nxt = mode_pair_r;
         ADDR_FIFO_FULL:    rdata_nxt = 8'(lane_full_i);
         ADDR_FIFO_EMPTY:   rdata_nxt = 8'(lane_empty_i);
         default:           rdata_nxt = 8'h00;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         rdata_r <= RESET_VALUE;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   assign reg_rdata_o = rdata_r;
   assign irq_n_o     = ~(|capd);

   irq_level_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      irq_n_o == !(|(mode & stat)))
      else $error("interrupt level disagrees with captured flags");
   lane_sticky_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (lane_err_r && link_enable_i && link_en_prev_r) |=> lane_err_r)
      else $error("lane error dropped while link stayed up");
   lane_set_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (link_enable_i && |lane_full_i) |=> lane_err_r)
      else $error("lane full did not raise error");
   reserved_zero_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (link_stat[0] == 1'b0) && (pair_stat[6] == 1'b0) &&
      (pat_stat[7:4] == 4'h0))
      else $error("reserved status bit nonzero");
   mode_write_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      hit(wr_req, ADDR_MODE_PATTERN) |=>
      mode_pat_r == ($past(reg_wdata_i) & MASK_PATTERN))
      else $error("mode register write lost");
   read_full_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      reg_addr_i == ADDR_FIFO_FULL |=> reg_rdata_o == 8'($past(lane_full_i)))
      else $error("fifo full readback wrong");
endmodule : irq_status_latch_bank

// [host_model.sv]
// Host model: drives register accesses on the device port
`timescale 1ns/10ps
module host_model (
   input  wire logic       clk_i,   // Device clock
   output logic      [9:0] addr_o,  // Register address
   output logic            wr_o,    // Write strobe
   output logic      [7:0] wdata_o, // Write data
   output logic            rd_o     // Read issued this cycle
);
   initial begin
      addr_o = 10'h3FF;
      wr_o = 1'b0;
      wdata_o = 8'h00;
      rd_o = 1'b0;
   end
   // One access per cycle, launched at the falling edge, held to the next
   task automatic acc(input logic [9:0] a, input logic w,
                      input logic [7:0] d, input logic r);
      @(negedge clk_i);
      addr_o <= a;
      wr_o <= w;
      wdata_o <= d;
      rd_o <= r;
   endtask : acc
endmodule : host_model

// [irq_status_latch_bank_test.sv]
// Self-checking bench for the interrupt status bank
`timescale 1ns/10ps
module irq_status_latch_bank_test;
   import irq_status_pkg::*;
   logic       clk, rst_n, wr, rd, rd_seen, irq_n;
   logic       pll, link_en, pwr, blk, nco;
   logic [9:0] addr;
   logic [7:0] wdata, rdata, full, empty;
   logic [3:0] pat;
   logic [31:0] r;
   logic [7:0] expq[$];
   int         err_count, n_compared;

   irq_status_latch_bank #(.LANES(8)) u_dut (
      .clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(addr), .reg_wr_i(wr),
      .reg_wdata_i(wdata), .reg_rdata_o(rdata), .pll_locked_i(pll),
      .link_enable_i(link_en), .lane_full_i(full), .lane_empty_i(empty),
      .pattern_err_i(pat), .power_over_i(pwr), .blank_done_i(blk),
      .nco_trip_i(nco), .irq_n_o(irq_n));
   host_model u_host (.clk_i(clk), .addr_o(addr), .wr_o(wr),
      .wdata_o(wdata), .rd_o(rd));

   always #10 clk = ~clk;

   task automatic chk(input string nm, input logic [7:0] e, g);
      n_compared++;
      if (g !== e) begin
         err_count++;
         $display("MISMATCH %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   task automatic chk_irq(input logic e);
      chk("irq_n", {7'h00, e}, {7'h00, irq_n});
   endtask : chk_irq
   task automatic final_report;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : final_report
   task automatic rd_reg(input logic [9:0] a, input logic [7:0] e);
      expq.push_back(e);
      u_host.acc(a, 1'b0, 8'h00, 1'b1);
   endtask : rd_reg
   task automatic wr_reg(input logic [9:0] a, input logic [7:0] d);
      u_host.acc(a, 1'b1, d, 1'b0);
   endtask : wr_reg
   task automatic idle(input int n);
      repeat (n) u_host.acc(10'h3FF, 1'b0, 8'h00, 1'b0);
   endtask : idle

   // Read data lands one edge after the address was taken
   always @(posedge clk) rd_seen <= rd;
   always @(negedge clk) if (rd_seen === 1'b1) begin
      chk("rdata", expq.pop_front(), rdata);
   end

   initial begin
      #200000;
      err_count++;
      final_report();
   end

   initial begin
      {clk, rst_n, pll, pwr, blk, nco, pat} = '0;
      {link_en, full, empty} = {1'b1, 16'h0000};
      void'($urandom(20));
      repeat (16) @(negedge clk);
      rst_n = 1'b1;
      rd_reg(ADDR_DAC_PATTERN, RESET_VALUE);
      rd_reg(ADDR_PAIR_A, RESET_VALUE);
      rd_reg(ADDR_MODE_PATTERN, 8'h00);
      idle(2);
      chk_irq(1'b1);
      for (int i = 0; i < 6; i++) begin
         r = $urandom;
         {pll, pwr, blk, nco, pat} = r[7:0];
         idle(2);
         rd_reg(ADDR_DAC_PATTERN, {4'h0, r[3:0]});
         rd_reg(ADDR_PAIR_A, {r[6], 1'b0, r[5:4], 4'h0});
         rd_reg(ADDR_LINK_STATUS, {5'h00, r[7], 2'b00});
         idle(1);
      end
      {pll, pwr, blk, nco, pat} = '0;
      wr_reg(ADDR_MODE_PATTERN, 8'hFF);
      wr_reg(ADDR_MODE_PAIR_A, 8'hFF);
      wr_reg(ADDR_MODE_LINK, 8'h04);
      rd_reg(ADDR_MODE_PATTERN, 8'h0F);
      rd_reg(ADDR_MODE_PAIR_A, MASK_PAIR_A);
      {pll, pwr, blk, nco, pat} = 8'hFF;
      idle(2);
      {pll, pwr, blk, nco, pat} = '0;
      idle(2);
      chk_irq(1'b0);
      rd_reg(ADDR_DAC_PATTERN, 8'h0F);
      rd_reg(ADDR_PAIR_A, MASK_PAIR_A);
      wr_reg(ADDR_DAC_PATTERN, 8'h00);
      wr_reg(ADDR_DAC_PATTERN, 8'h05);
      rd_reg(ADDR_DAC_PATTERN, 8'h0A);
      wr_reg(ADDR_DAC_PATTERN, 8'h0A);
      wr_reg(ADDR_PAIR_A, MASK_PAIR_A);
      idle(2);
      chk_irq(1'b0);
      rd_reg(ADDR_LINK_STATUS, 8'h04);
      wr_reg(ADDR_LINK_STATUS, 8'h04);
      idle(2);
      chk_irq(1'b1);
      rd_reg(ADDR_DAC_PATTERN, 8'h00);
      rd_reg(ADDR_PAIR_A, 8'h00);
      r = $urandom;
      full = r[7:0] | 8'h01;
      empty = r[15:8];
      idle(2);
      rd_reg(ADDR_FIFO_FULL, full);
      rd_reg(ADDR_FIFO_EMPTY, empty);
      idle(1);
      {full, empty} = 16'h0000;
      idle(2);
      rd_reg(ADDR_LINK_STATUS, 8'h02);
      link_en = 1'b0;
      idle(2);
      link_en = 1'b1;
      idle(2);
      rd_reg(ADDR_LINK_STATUS, 8'h00);
      // Lane error in capture mode: survives link restart until cleared
      wr_reg(ADDR_MODE_LINK, 8'h06);
      rd_reg(ADDR_MODE_LINK, 8'h06);
      full = 8'h01;
      idle(1);
      full = 8'h00;
      idle(2);
      chk_irq(1'b0);
      rd_reg(ADDR_LINK_STATUS, 8'h02);
      link_en = 1'b0;
      idle(2);
      link_en = 1'b1;
      idle(2);
      rd_reg(ADDR_LINK_STATUS, 8'h02);
      wr_reg(ADDR_LINK_STATUS, 8'h02);
      rd_reg(ADDR_LINK_STATUS, 8'h00);
      idle(1);
      chk_irq(1'b1);
      wr_reg(10'h3FE, 8'hFF);
      rd_reg(10'h3FE, 8'h00);
      idle(3);
      final_report();
   end
endmodule : irq_status_latch_bank_test
